// *** hdl/uart_irq_pkg.sv ***
package uart_irq_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned FLAG_W = 13;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_RAW    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_MASKED = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 8'h44;

  // ------------------------------------------------------------------
  // flag bit positions (same in every register of the group)
  // ------------------------------------------------------------------
  localparam int unsigned BIT_CTS        = 1;
  localparam int unsigned BIT_RX         = 4;
  localparam int unsigned BIT_TX         = 5;
  localparam int unsigned BIT_RX_TIMEOUT = 6;
  localparam int unsigned BIT_FRAMING    = 7;
  localparam int unsigned BIT_PARITY     = 8;
  localparam int unsigned BIT_BREAK      = 9;
  localparam int unsigned BIT_OVERRUN    = 10;
  localparam int unsigned BIT_STOP_CHAR  = 11;
  localparam int unsigned BIT_TX_EMPTY   = 12;

  // bits 1 and 4..12 exist, the rest are reserved
  localparam logic [FLAG_W-1:0] FLAG_VALID = 13'h1FF2;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 13'h0000;

  // ------------------------------------------------------------------
  // bus responses and register select
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_ENABLE,
    SEL_RAW,
    SEL_MASKED,
    SEL_CLEAR
  } reg_sel_e;

endpackage

// *** hdl/uart_irq_if.sv ***
`timescale 1ns/100ps
interface uart_irq_if;
  import uart_irq_pkg::*;

  logic [FLAG_W-1:0] set;
  logic [FLAG_W-1:0] clr;
  logic [FLAG_W-1:0] enable;
  logic [FLAG_W-1:0] raw;
  logic [FLAG_W-1:0] masked;

  modport bank (
    input  set,
    input  clr,
    input  enable,
    output raw,
    output masked
  );

  modport ctrl (
    output set,
    output clr,
    output enable,
    input  raw,
    input  masked
  );
endinterface

// *** hdl/uart_irq_flags.sv ***
`timescale 1ns/100ps
module uart_irq_flags
  import uart_irq_pkg::*;
(
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  // flag traffic
  uart_irq_if.bank    flags
);

  typedef struct packed {
    logic [FLAG_W-1:0] raw_interrupt_status;
  } flags_state_s;

  flags_state_s q;
  flags_state_s d;

  // ------------------------------------------------------------------
  // sticky raw flags
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.raw_interrupt_status = ((q.raw_interrupt_status & ~flags.clr) | flags.set) & FLAG_VALID;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q.raw_interrupt_status <= FLAG_RESET;
    end else begin
      q <= d;
    end
  end

  assign flags.raw = q.raw_interrupt_status;
  assign flags.masked = q.raw_interrupt_status & flags.enable;

endmodule // uart_irq_flags

// *** hdl/uart_irq_ctrl.sv ***
// Operation
// - The clear-to-send raw pending flag sits read-only at bit 1 of the raw status register.
// - Receive, transmit and receive-timeout raw flags sit at bits 4, 5 and 6 of the raw status register.
// - Framing, parity, break and overrun raw flags sit at bits 7, 8, 9 and 10 of the raw status register.
// - The stop-character raw flag sits at bit 11 and the transmit-FIFO-empty raw flag at bit 12.
// - A flag reads 1 while its interrupt is pending, else 0, and every flag is 0 after reset.
// - A read-only masked status register at 0x40 holds the clear-to-send masked flag at bit 1.
// - The masked register holds receive to receive-timeout at bits 4-6 and the error flags at bits 7-10.
// - The masked register holds the stop-character flag at bit 11 and transmit-FIFO-empty at bit 12.
// - Writing the clear register at 0x44 clears each flag written 1 and leaves those written 0; an event in the same cycle keeps its flag set.
// - Clear bits line up with status bits: 1, 4 to 10, 11 and 12.
// - A masked flag is 1 only when its raw flag is pending and its enable bit is 1.
// - The raw status register sits at offset 0x3C.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module uart_irq_ctrl
  import uart_irq_pkg::*;
(
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // event pulses from the serial datapath, one bit per flag position
  input  wire logic [FLAG_W-1:0]   i_irq_event,
  // interrupt request
  output logic                     o_irq,
  // axi4-lite write address
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  input  wire logic [ADDR_W-1:0]   i_awaddr,
  input  wire logic [2:0]          i_awprot,
  // axi4-lite write data
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  input  wire logic [DATA_W-1:0]   i_wdata,
  input  wire logic [STRB_W-1:0]   i_wstrb,
  // axi4-lite write response
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  output logic [1:0]               o_bresp,
  // axi4-lite read address
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  input  wire logic [ADDR_W-1:0]   i_araddr,
  input  wire logic [2:0]          i_arprot,
  // axi4-lite read data
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  output logic [DATA_W-1:0]        o_rdata,
  output logic [1:0]               o_rresp
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr[ADDR_W-1:2] == OFS_ENABLE[ADDR_W-1:2]) sel = SEL_ENABLE;
    if (addr[ADDR_W-1:2] == OFS_RAW[ADDR_W-1:2]) sel = SEL_RAW;
    if (addr[ADDR_W-1:2] == OFS_MASKED[ADDR_W-1:2]) sel = SEL_MASKED;
    if (addr[ADDR_W-1:2] == OFS_CLEAR[ADDR_W-1:2]) sel = SEL_CLEAR;
    return sel;
  endfunction

  function automatic logic [DATA_W-1:0] lane_mask(input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [FLAG_W-1:0] enable;
  } ctrl_state_s;

  ctrl_state_s q;
  ctrl_state_s d;

  uart_irq_if flags ();

  logic              wr_go;
  reg_sel_e          wr_sel;
  reg_sel_e          rd_sel;
  logic [DATA_W-1:0] wr_bits;
  logic [DATA_W-1:0] wr_lanes;
  logic [FLAG_W-1:0] clr_pulse;

  // the unused prot inputs carry no meaning for this slave
  logic              prot_unused;
  assign prot_unused = ^{i_awprot, i_arprot};

  // ------------------------------------------------------------------
  // flag bank
  // ------------------------------------------------------------------
  uart_irq_flags u_flags (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .flags (flags.bank)
  );

  // events come from logic on i_clk, so no synchroniser is needed
  assign flags.set    = i_irq_event & FLAG_VALID;
  assign flags.enable = q.enable;
  assign flags.clr    = clr_pulse;

  // ------------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------------
  // address and data are taken in either order; the write fires once both are held and no write response is pending
  assign o_awready = ~q.aw_held;
  assign o_wready  = ~q.w_held;
  assign o_arready = ~q.rvalid;
  assign wr_go     = q.aw_held & q.w_held & ~q.bvalid;
  assign wr_sel    = reg_decode(q.aw_addr);
  assign rd_sel    = reg_decode(i_araddr);
  assign wr_lanes  = lane_mask(q.w_strb);
  assign wr_bits   = q.w_data & wr_lanes;

  assign clr_pulse = (wr_go && wr_sel == SEL_CLEAR) ? (wr_bits[FLAG_W-1:0] & FLAG_VALID) : FLAG_RESET;

  always_comb begin
    d = q;
    if (i_awvalid && o_awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      d.w_held = 1'b1;
      d.w_data = i_wdata;
      d.w_strb = i_wstrb;
    end
    if (q.bvalid && i_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // reserved enable bits stay zero whatever software writes
      if (wr_sel == SEL_ENABLE) begin
        d.enable = (q.enable & ~wr_lanes[FLAG_W-1:0]) | (wr_bits[FLAG_W-1:0] & FLAG_VALID);
      end
    end
    if (q.rvalid && i_rready) begin
      d.rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      case (rd_sel)
        SEL_ENABLE: d.rdata[FLAG_W-1:0] = q.enable;
        SEL_RAW: d.rdata[FLAG_W-1:0] = flags.raw;
        SEL_MASKED: d.rdata[FLAG_W-1:0] = flags.masked;
        // write-only register reads as zero
        SEL_CLEAR: d.rdata = '0;
        default: d.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q.aw_held <= 1'b0;
      q.aw_addr <= 8'h00;
      q.w_held  <= 1'b0;
      q.w_data  <= 32'h00000000;
      q.w_strb  <= 4'h0;
      q.bvalid  <= 1'b0;
      q.bresp   <= RESP_OKAY;
      q.rvalid  <= 1'b0;
      q.rdata   <= 32'h00000000;
      q.rresp   <= RESP_OKAY;
      q.enable  <= FLAG_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_bvalid = q.bvalid;
  assign o_bresp  = q.bresp;
  assign o_rvalid = q.rvalid;
  assign o_rdata  = q.rdata;
  assign o_rresp  = q.rresp;

  assign o_irq = |flags.masked;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [FLAG_W-1:0] clr_only;
  logic [FLAG_W-1:0] set_valid;
  logic [FLAG_W-1:0] set_clr;
  assign clr_only  = clr_pulse & ~flags.set;
  assign set_valid = flags.set;
  assign set_clr   = set_valid & clr_pulse;

  sequence s_read_raw;
    i_arvalid && o_arready && rd_sel == SEL_RAW;
  endsequence

  sequence s_read_masked;
    i_arvalid && o_arready && rd_sel == SEL_MASKED;
  endsequence

  sequence s_clear_write;
    wr_go && wr_sel == SEL_CLEAR;
  endsequence

  sequence s_read_enable;
    i_arvalid && o_arready && rd_sel == SEL_ENABLE;
  endsequence

  sequence s_read_none;
    i_arvalid && o_arready && rd_sel == SEL_NONE;
  endsequence

  a_reserved_bits_zero: assert property ((flags.raw & ~FLAG_VALID) == FLAG_RESET)
    else $error("reserved raw status bit set");

  a_event_sets_flag: assert property (
    (set_valid != FLAG_RESET) |=> ((flags.raw & $past(set_valid)) == $past(set_valid)))
    else $error("event did not set its raw flag");

  a_flags_hold_idle: assert property (
    (set_valid == FLAG_RESET && clr_pulse == FLAG_RESET) |=> flags.raw == $past(flags.raw))
    else $error("raw flags changed without cause");

  a_clear_drops_flag: assert property (
    (clr_only != FLAG_RESET) |=> ((flags.raw & $past(clr_only)) == FLAG_RESET))
    else $error("clear left a flag pending");

  a_set_beats_clear: assert property (
    (set_clr != FLAG_RESET) |=> ((flags.raw & $past(set_clr)) == $past(set_clr)))
    else $error("clear won over an event in the same cycle");

  a_clear_write_path: assert property (
    s_clear_write |-> clr_pulse == (wr_bits[FLAG_W-1:0] & FLAG_VALID) ##1 o_bvalid)
    else $error("clear write mapped wrongly or not answered");

  a_clear_reserved_ignored: assert property ((clr_pulse & ~FLAG_VALID) == FLAG_RESET)
    else $error("clear pulse reached a reserved bit");

  a_other_write_keeps: assert property ((wr_go && wr_sel != SEL_CLEAR) |-> clr_pulse == FLAG_RESET)
    else $error("write to another register cleared a flag");

  a_write_answered: assert property (wr_go |=> o_bvalid)
    else $error("write fired without a response");

  a_masked_view: assert property (flags.masked == (flags.raw & q.enable))
    else $error("masked flags differ from raw and enable");

  a_masked_subset: assert property ((flags.masked & ~flags.raw) == FLAG_RESET)
    else $error("masked flag set without its raw flag");

  a_enable_reserved_zero: assert property ((q.enable & ~FLAG_VALID) == FLAG_RESET)
    else $error("reserved enable bit set");

  a_enable_write_lands: assert property (
    (wr_go && wr_sel == SEL_ENABLE && q.w_strb == 4'hF) |=> q.enable == ($past(q.w_data[FLAG_W-1:0]) & FLAG_VALID))
    else $error("full enable write did not land");

  a_irq_level: assert property (o_irq == (|(flags.raw & q.enable)))
    else $error("interrupt output disagrees with enabled flags");

  a_irq_quiet_masked: assert property ((q.enable == FLAG_RESET) |-> !o_irq)
    else $error("interrupt raised with every source disabled");

  a_read_raw_data: assert property (s_read_raw |=> o_rvalid && o_rdata == {19'h00000, $past(flags.raw)})
    else $error("raw status read returned wrong data");

  a_raw_read_okay: assert property (s_read_raw |=> o_rresp == RESP_OKAY)
    else $error("raw status read not answered okay");

  a_read_masked_data: assert property (
    s_read_masked |=> o_rvalid && o_rdata == {19'h00000, $past(flags.masked)})
    else $error("masked status read returned wrong data");

  a_masked_bits_map: assert property (
    s_read_masked ##1 1'b1 |-> o_rdata[FLAG_W-1:0] == ($past(flags.raw) & $past(q.enable)))
    else $error("masked read bit layout wrong");

  a_read_enable_data: assert property (s_read_enable |=> o_rdata == {19'h00000, $past(q.enable)})
    else $error("enable read returned wrong data");

  a_unmapped_read_err: assert property (
    s_read_none |=> o_rvalid && o_rresp == RESP_SLVERR && o_rdata == 32'h00000000)
    else $error("unmapped read not refused");

  a_resp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before taken");

  a_read_data_holds: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data changed before taken");

endmodule // uart_irq_ctrl

// *** sim/uart_interrupt_status_clear_bench.sv ***
`timescale 1ns/100ps
module uart_interrupt_status_clear_bench;
  import uart_irq_pkg::*;

  logic              i_clk, i_rst, o_irq;
  logic [FLAG_W-1:0] i_irq_event;
  logic              i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  logic              i_arvalid, o_arready, o_rvalid, i_rready;
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [STRB_W-1:0] i_wstrb;
  logic [2:0]        i_awprot, i_arprot;
  logic [1:0]        o_bresp, o_rresp;
  int                failures, checks_done;

  localparam int unsigned FLAG_BITS [10] = '{BIT_CTS, BIT_RX, BIT_TX, BIT_RX_TIMEOUT, BIT_FRAMING,
                                             BIT_PARITY, BIT_BREAK, BIT_OVERRUN, BIT_STOP_CHAR, BIT_TX_EMPTY};

  uart_irq_ctrl u_uart_irq_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_irq_event(i_irq_event), .o_irq(o_irq),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(i_awprot),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(i_arprot),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    failures++;
    $display("mismatch at %0t: bus wait ran out", $time);
    conclude();
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled at the falling edge, so it is settled when the rising edge takes it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
    logic ra, rw, rb;
    int n;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge i_clk);
      ra = o_awready;
      rw = o_wready;
      rb = o_bvalid;
      r = o_bresp;
      @(posedge i_clk);
      if (ra) i_awvalid <= 1'b0;
      if (rw) i_wvalid <= 1'b0;
      if (rb) begin
        i_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) timeout();
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
    logic ra, rv;
    int n;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge i_clk);
      ra = o_arready;
      rv = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clk);
      if (ra) i_arvalid <= 1'b0;
      if (rv) begin
        i_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) timeout();
  endtask

  task automatic pulse(input logic [FLAG_W-1:0] b);
    @(posedge i_clk);
    i_irq_event <= b;
    @(posedge i_clk);
    i_irq_event <= '0;
  endtask

  task automatic irq_is(input logic e);
    @(negedge i_clk);
    check({31'h0, o_irq}, {31'h0, e});
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_state();
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_RAW, d, r);
    check({d, 30'h0, r}, 64'h0);
    rd(OFS_MASKED, d, r);
    check(d, 32'h0);
    rd(OFS_ENABLE, d, r);
    check(d, 32'h0);
    irq_is(1'b0);
  endtask

  task automatic t_raw_flags();
    logic [31:0] d, e;
    logic [1:0] r;
    for (int k = 0; k < 10; k++) begin
      e = 32'h0000_0001 << FLAG_BITS[k];
      pulse(e[FLAG_W-1:0]);
      rd(OFS_RAW, d, r);
      check(d, e);
      rd(OFS_MASKED, d, r);
      check(d, 32'h0);
      irq_is(1'b0);
      wr(OFS_CLEAR, e, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
      rd(OFS_RAW, d, r);
      check(d, 32'h0);
    end
    pulse(13'h000D);
    rd(OFS_RAW, d, r);
    check(d, 32'h0);
  endtask

  task automatic t_masked_clear();
    logic [31:0] d;
    logic [1:0] r;
    pulse(FLAG_VALID);
    wr(OFS_ENABLE, 32'h0000_0A52, r);
    rd(OFS_MASKED, d, r);
    check(d, 32'h0000_0A52);
    irq_is(1'b1);
    wr(OFS_ENABLE, 32'h0000_1FF2, r);
    rd(OFS_MASKED, d, r);
    check(d, 32'h0000_1FF2);
    wr(OFS_CLEAR, 32'h0000_1550, r);
    rd(OFS_RAW, d, r);
    check(d, 32'h0000_0AA2);
    rd(OFS_MASKED, d, r);
    check(d, 32'h0000_0AA2);
    wr(OFS_CLEAR, 32'h0000_0AA2, r);
    rd(OFS_MASKED, d, r);
    check(d, 32'h0);
    irq_is(1'b0);
  endtask

  task automatic t_bus_edges();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h48, d, r);
    check({d, 30'h0, r}, {32'h0, 30'h0, RESP_SLVERR});
    pulse(FLAG_VALID);
    wr(OFS_RAW, 32'h0000_0000, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_RAW, d, r);
    check(d, 32'h0000_1FF2);
    wr(OFS_CLEAR, 32'h0000_0000, r);
    rd(OFS_RAW, d, r);
    check(d, 32'h0000_1FF2);
    rd(OFS_CLEAR, d, r);
    check({d, 30'h0, r}, {32'h0, 30'h0, RESP_OKAY});
    irq_is(1'b1);
    // only byte lane 0 written: bits 8 and up keep their value
    @(posedge i_clk);
    i_wstrb <= 4'h1;
    wr(OFS_ENABLE, 32'h0000_0000, r);
    rd(OFS_ENABLE, d, r);
    check(d, 32'h0000_1F00);
    wr(OFS_CLEAR, 32'h0000_1FF2, r);
    rd(OFS_RAW, d, r);
    check(d, 32'h0000_1F00);
    @(posedge i_clk);
    i_wstrb <= 4'hF;
    rd(OFS_MASKED, d, r);
    check(d, 32'h0000_1F00);
  endtask

  task automatic t_mid_reset();
    logic [31:0] d;
    logic [1:0] r;
    irq_is(1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    irq_is(1'b0);
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(OFS_RAW, d, r);
    check(d, 32'h0);
    rd(OFS_ENABLE, d, r);
    check(d, 32'h0);
    irq_is(1'b0);
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    i_rst = 1'b1;
    i_irq_event = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_awaddr = '0;
    i_araddr = '0;
    i_wdata = '0;
    i_wstrb = 4'hF;
    i_awprot = 3'h0;
    i_arprot = 3'h0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset_state();
    t_raw_flags();
    t_masked_clear();
    t_bus_edges();
    t_mid_reset();
    conclude();
  end

endmodule // uart_interrupt_status_clear_bench
